// ==== tmr_regs.svh ====
// Register offsets, field positions, reset values and the prescale width of the dual timer
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
// Register indices (byte address = 4 * index)
`define TMR_IDX_CTRL     8'h88
`define TMR_IDX_MODE     8'h89
`define TMR_IDX_T0_LOW   8'h8A
`define TMR_IDX_T1_LOW   8'h8B
`define TMR_IDX_T0_HIGH  8'h8C
`define TMR_IDX_T1_HIGH  8'h8D
`define TMR_IDX_IRQ_STAT 8'h90
`define TMR_IDX_IRQ_MASK 8'h91
`define TMR_IDX_ACK      8'h92
// Control register fields
`define TMR_CTRL_OVF1    7
`define TMR_CTRL_RUN1    6
`define TMR_CTRL_OVF0    5
`define TMR_CTRL_RUN0    4
// Mode register fields, per timer nibble
`define TMR_MODE_GATE    3
`define TMR_MODE_SRC     2
// Interrupt status bits
`define TMR_IRQ_OVF0     0
`define TMR_IRQ_OVF1     1
// Service acknowledge bits
`define TMR_ACK_T0       0
`define TMR_ACK_T1       1
// Reset values
`define TMR_RST_BYTE     8'h00
// Prescale width of the 13-bit mode
`define TMR_PRESCALE_W   5
`endif

// ==== tmr_pkg.sv ====
// Types shared by the dual timer
package tmr_pkg;
	typedef enum logic [3:0] {
		MODE_13BIT  = 4'b0001,
		MODE_16BIT  = 4'b0010,
		MODE_RELOAD = 4'b0100,
		MODE_SPLIT  = 4'b1000
	} tmr_mode_e;
	typedef struct packed {
		logic       gate;
		logic       src;
		logic [1:0] mode;
	} tmr_cfg_s;
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [7:0] idx;
		logic [7:0] wdata;
	} wb_req_s;
	function automatic tmr_mode_e decode_mode(input logic [1:0] m);
		case (m)
			2'b00:   decode_mode = MODE_13BIT;
			2'b01:   decode_mode = MODE_16BIT;
			2'b10:   decode_mode = MODE_RELOAD;
			default: decode_mode = MODE_SPLIT;
		endcase
	endfunction : decode_mode
endpackage : tmr_pkg

// ==== dual_timer.sv ====
// Dual timer/counter with a classic Wishbone register slave
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tmr_regs.svh"

// How it works
// (RQ1) Mode 00 counts 13 bits, the low byte's bottom five bits prescaling the high byte.
// (RQ2) Mode 01 counts a full 16 bits over the high and low bytes.
// (RQ3) Mode 10 counts the low byte and reloads it from the high byte on overflow.
// (RQ4) Timer 0 in mode 11 runs its low byte as an 8-bit counter under its own controls.
// (RQ5) Timer 0 in mode 11 runs its high byte on the clock alone under timer 1's run bit.
// (RQ6) Timer 1 in mode 11 holds its count unchanged.
// (RQ7) Both high count bytes are readable and writable at indices 8Ch and 8Dh.
// (RQ8) Timer 0's low count byte is readable and writable at index 8Ah.
// (RQ9) Overflow sets the timer's flag, servicing clears it, and software may write it; with timer 0 in mode 11, timer 1's overflow sets no flag.
// (RQ10) With gate set a timer, other than timer 0's high byte in mode 11, counts only while its interrupt pin is high and it runs.
// (RQ11) Source clear counts the clock, source set counts falling edges of the count pin.
// (RQ12) The count holds whenever the run bit is clear, except timer 0's high byte in mode 11, which follows timer 1's run bit.
// (RQ13) Count and gate pins are synchronised first, and each falling edge counts once.
module dual_timer import tmr_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// External pins
	input  wire logic              count_pin_0,
	input  wire logic              count_pin_1,
	input  wire logic              ext_irq_pin_0,
	input  wire logic              ext_irq_pin_1,
	// Interrupt
	output logic                   irq
);
	// Elaboration check: the index field needs address bits 9..2
	if (ADDR_W < 10) begin : g_addr_chk
		$error("ADDR_W too small for the register map");
	end

	// ************************************************************
	// Registers and bus decode
	// ************************************************************
	logic [7:0] ctrl_r, mode_r, t0_low_r, t1_low_r, t0_high_r, t1_high_r;
	logic [1:0] stat_r, mask_r;
	logic       ack_r;
	wb_req_s    req;
	logic       acc, wr, rd, lane0, in_map;
	tmr_cfg_s   cfg0, cfg1;
	tmr_mode_e  m0, m1;

	assign req   = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
		idx: wb_adr_i[9:2], wdata: wb_dat_i[7:0]};
	assign acc   = req.cyc && req.stb && !ack_r;
	assign lane0 = wb_sel_i[0];
	// Shift instead of a part-select so ADDR_W of exactly 10 stays legal
	assign in_map = ((wb_adr_i >> 10) == '0);
	assign wr    = acc && req.we && lane0 && in_map;
	assign rd    = acc && !req.we;
	assign cfg0  = mode_r[3:0];
	assign cfg1  = mode_r[7:4];
	assign m0    = decode_mode(cfg0.mode);
	assign m1    = decode_mode(cfg1.mode);
	assign wb_ack_o = ack_r;
	assign irq   = |(stat_r & mask_r);

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ack_r <= 1'b0;
		else
			ack_r <= acc;
	end

	// ************************************************************
	// Pin synchronisers and edge detect
	// ************************************************************
	logic [1:0] cnt_s1, cnt_s2, cnt_d, gate_s1, gate_s2;
	logic [1:0] fall;

	// RQ13 two-flop synchronise
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_s1  <= 2'h3;
			cnt_s2  <= 2'h3;
			cnt_d   <= 2'h3;
			gate_s1 <= 2'h0;
			gate_s2 <= 2'h0;
		end else begin
			cnt_s1  <= {count_pin_1, count_pin_0};
			cnt_s2  <= cnt_s1;
			cnt_d   <= cnt_s2;
			gate_s1 <= {ext_irq_pin_1, ext_irq_pin_0};
			gate_s2 <= gate_s1;
		end
	end
	// RQ13 one pulse per edge
	assign fall = cnt_d & ~cnt_s2;

	// ************************************************************
	// Count enables
	// ************************************************************
	logic run0, run1, en0, en1, tick0, tick1, tick0h;

	// RQ10 gate qualifies run
	assign run0  = ctrl_r[`TMR_CTRL_RUN0] && (!cfg0.gate || gate_s2[0]);
	assign run1  = ctrl_r[`TMR_CTRL_RUN1] && (!cfg1.gate || gate_s2[1]);
	// RQ11 clock or pin edge
	assign en0   = cfg0.src ? fall[0] : 1'b1;
	assign en1   = cfg1.src ? fall[1] : 1'b1;
	// RQ12 hold when stopped
	assign tick0 = run0 && en0;
	// RQ6 timer 1 halts in split
	assign tick1 = run1 && en1 && (m1 != MODE_SPLIT);
	// RQ5 high byte on clock, timer 1 run
	assign tick0h = ctrl_r[`TMR_CTRL_RUN1];

	// ************************************************************
	// Counter next values (shared per timer)
	// ************************************************************
	logic [7:0] n0l, n0h, n1l, n1h;
	logic       ov0, ov1, ovsp;

	always_comb begin
		n0l = t0_low_r; n0h = t0_high_r; ov0 = 1'b0; ovsp = 1'b0;
		case (m0)
			// RQ1 13-bit prescaled
			MODE_13BIT: if (tick0) begin
				n0l = {3'h0, t0_low_r[4:0] + 5'h01};
				if (t0_low_r[4:0] == 5'h1F) begin
					n0h = t0_high_r + 8'h01;
					ov0 = (t0_high_r == 8'hFF);
				end
			end
			// RQ2 16-bit count
			MODE_16BIT: if (tick0) begin
				{n0h, n0l} = {t0_high_r, t0_low_r} + 16'h0001;
				ov0 = ({t0_high_r, t0_low_r} == 16'hFFFF);
			end
			// RQ3 reload from high
			MODE_RELOAD: if (tick0) begin
				ov0 = (t0_low_r == 8'hFF);
				n0l = ov0 ? t0_high_r : t0_low_r + 8'h01;
			end
			// RQ4 RQ5 split byte timers
			MODE_SPLIT: begin
				if (tick0) begin
					n0l = t0_low_r + 8'h01;
					ov0 = (t0_low_r == 8'hFF);
				end
				if (tick0h) begin
					n0h  = t0_high_r + 8'h01;
					ovsp = (t0_high_r == 8'hFF);
				end
			end
			default: ;
		endcase
	end

	always_comb begin
		n1l = t1_low_r; n1h = t1_high_r; ov1 = 1'b0;
		case (m1)
			// RQ1 13-bit prescaled
			MODE_13BIT: if (tick1) begin
				n1l = {3'h0, t1_low_r[4:0] + 5'h01};
				if (t1_low_r[4:0] == 5'h1F) begin
					n1h = t1_high_r + 8'h01;
					ov1 = (t1_high_r == 8'hFF);
				end
			end
			// RQ2 16-bit count
			MODE_16BIT: if (tick1) begin
				{n1h, n1l} = {t1_high_r, t1_low_r} + 16'h0001;
				ov1 = ({t1_high_r, t1_low_r} == 16'hFFFF);
			end
			// RQ3 reload from high
			MODE_RELOAD: if (tick1) begin
				ov1 = (t1_low_r == 8'hFF);
				n1l = ov1 ? t1_high_r : t1_low_r + 8'h01;
			end
			default: ;
		endcase
	end

	// ************************************************************
	// Count registers, software write wins over counting
	// ************************************************************
	// RQ7 RQ8 count byte access
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			t0_low_r  <= `TMR_RST_BYTE;
			t0_high_r <= `TMR_RST_BYTE;
			t1_low_r  <= `TMR_RST_BYTE;
			t1_high_r <= `TMR_RST_BYTE;
		end else begin
			t0_low_r  <= (wr && req.idx == `TMR_IDX_T0_LOW)  ? req.wdata : n0l;
			t0_high_r <= (wr && req.idx == `TMR_IDX_T0_HIGH) ? req.wdata : n0h;
			t1_low_r  <= (wr && req.idx == `TMR_IDX_T1_LOW)  ? req.wdata : n1l;
			t1_high_r <= (wr && req.idx == `TMR_IDX_T1_HIGH) ? req.wdata : n1h;
		end
	end

	// ************************************************************
	// Control, mode, overflow flags
	// ************************************************************
	logic set0, set1, svc0, svc1;
	assign set0 = ov0;
	// In split mode timer 1's flag belongs to the high byte of timer 0
	assign set1 = (m0 == MODE_SPLIT) ? ovsp : ov1;
	assign svc0 = wr && req.idx == `TMR_IDX_ACK && req.wdata[`TMR_ACK_T0];
	assign svc1 = wr && req.idx == `TMR_IDX_ACK && req.wdata[`TMR_ACK_T1];

	// RQ9 set wins over clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `TMR_RST_BYTE;
			mode_r <= `TMR_RST_BYTE;
		end else begin
			if (wr && req.idx == `TMR_IDX_MODE)
				mode_r <= req.wdata;
			if (wr && req.idx == `TMR_IDX_CTRL)
				ctrl_r <= req.wdata;
			else begin
				if (svc0)
					ctrl_r[`TMR_CTRL_OVF0] <= 1'b0;
				if (svc1)
					ctrl_r[`TMR_CTRL_OVF1] <= 1'b0;
			end
			if (set0)
				ctrl_r[`TMR_CTRL_OVF0] <= 1'b1;
			if (set1)
				ctrl_r[`TMR_CTRL_OVF1] <= 1'b1;
		end
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	logic rd_stat;
	// An aliased read must not swallow pending events
	assign rd_stat = rd && in_map && req.idx == `TMR_IDX_IRQ_STAT;

	// Sticky status, cleared by read, new event wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_r <= 2'h0;
			mask_r <= 2'h0;
		end else begin
			stat_r <= (rd_stat ? 2'h0 : stat_r) | {set1, set0};
			if (wr && req.idx == `TMR_IDX_IRQ_MASK)
				mask_r <= req.wdata[1:0];
		end
	end

	// ************************************************************
	// Read data, unmapped reads return zero
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			wb_dat_o <= 32'h0;
		else if (rd) begin
			wb_dat_o <= 32'h0;
			if (in_map) begin
				case (req.idx)
					`TMR_IDX_CTRL:     wb_dat_o[7:0] <= ctrl_r;
					`TMR_IDX_MODE:     wb_dat_o[7:0] <= mode_r;
					`TMR_IDX_T0_LOW:   wb_dat_o[7:0] <= t0_low_r;
					`TMR_IDX_T1_LOW:   wb_dat_o[7:0] <= t1_low_r;
					`TMR_IDX_T0_HIGH:  wb_dat_o[7:0] <= t0_high_r;
					`TMR_IDX_T1_HIGH:  wb_dat_o[7:0] <= t1_high_r;
					`TMR_IDX_IRQ_STAT: wb_dat_o[1:0] <= stat_r;
					`TMR_IDX_IRQ_MASK: wb_dat_o[1:0] <= mask_r;
					default:           wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	AST_HOLD_STOPPED: assert property (@(posedge clk) disable iff (!rst_b) // RQ12
		(!ctrl_r[`TMR_CTRL_RUN1] && !wr && m1 == MODE_16BIT) |=> $stable(t1_low_r))
		else $error("timer 1 moved while stopped");
	AST_T1_SPLIT_HALT: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
		(m1 == MODE_SPLIT && !wr) |=> $stable({t1_high_r, t1_low_r}))
		else $error("timer 1 moved in split mode");
	AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
		(m0 == MODE_RELOAD && tick0 && t0_low_r == 8'hFF && !wr)
		|=> t0_low_r == $past(t0_high_r))
		else $error("reload value wrong");
	AST_OVF_FLAG: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
		ov0 |=> ctrl_r[`TMR_CTRL_OVF0])
		else $error("overflow flag not set");
	AST_PRESCALE: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
		(m0 == MODE_13BIT && tick0 && !wr) |=> t0_low_r[7:5] == 3'h0)
		else $error("prescaler exceeded five bits");
	AST_EDGE_ONCE: assert property (@(posedge clk) disable iff (!rst_b) // RQ13
		(cfg0.src && !fall[0] && !wr) |=> $stable(t0_low_r))
		else $error("count moved without a pin edge");
	AST_GATE: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
		(cfg0.gate && !gate_s2[0]) |-> !tick0)
		else $error("gated timer counted");
	AST_16BIT: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
		(m0 == MODE_16BIT && tick0 && !wr && !$past(wr))
		|=> {t0_high_r, t0_low_r} == $past({t0_high_r, t0_low_r}) + 16'h0001)
		else $error("16-bit count wrong");
endmodule : dual_timer

// ==== pin_partner.sv ====
// Pin-side partner model: drives the count and gate pins of the dual timer
`timescale 1ns/1ps

module pin_partner (
	// Clock
	input  wire logic clk,
	// Pins toward the timer
	output wire logic count_pin_0,
	output wire logic count_pin_1,
	output wire logic ext_irq_pin_0,
	output wire logic ext_irq_pin_1
);
	// Count pins idle high so a resting pin never looks like an edge
	logic [1:0] cnt_r = 2'b11;
	logic [1:0] gate_r = 2'b00;
	assign {count_pin_1, count_pin_0} = cnt_r;
	assign {ext_irq_pin_1, ext_irq_pin_0} = gate_r;

	task automatic gate(input int t, input int n);
		gate_r[t] <= 1'b1;
		repeat (n) @(posedge clk);
		gate_r[t] <= 1'b0;
	endtask : gate

	// falling edges, levels held long enough to pass the synchroniser
	task automatic edges(input int t, input int k);
		repeat (k) begin
			cnt_r[t] <= 1'b0;
			repeat (4) @(posedge clk);
			cnt_r[t] <= 1'b1;
			repeat (4) @(posedge clk);
		end
	endtask : edges
endmodule : pin_partner

// ==== dual_timer_counter_modes_test.sv ====
// Self-checking bench of the dual timer over its Wishbone port and pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module dual_timer_counter_modes_test;
	logic        clk, rst_b, cyc, stb, we, ack, irq, p0, p1, g0, g1;
	logic [11:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0]  sel, lanes;
	logic [7:0]  q, lo, hi, a;
	logic [16:0] e;
	int          bad_count = 0, n_tests = 0, cycles = 0, seed = 57, n, k0, k1;

	dual_timer u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.count_pin_0(p0), .count_pin_1(p1), .ext_irq_pin_0(g0), .ext_irq_pin_1(g1), .irq(irq));
	pin_partner u_pins (.clk(clk), .count_pin_0(p0), .count_pin_1(p1),
		.ext_irq_pin_0(g0), .ext_irq_pin_1(g1));

	// ****************************************
	// Bus cycles, expectations and the verdict
	// ****************************************
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	// Classic cycle: hold the request until ack is sampled, then idle one cycle
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] r);
		int i;
		i = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= {2'b00, idx, 2'b00};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 20) bad_count++;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, q);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] x);
		bus(1'b0, idx, 8'h00, q);
		`CHK(nm, x, q)
	endtask : rd

	// Steps one timer n times; returns {overflow, high, low}
	function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] l,
		input logic [7:0] h, input int n);
		logic o;
		o = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (m == 2'b00) begin
				if ({h, l[4:0]} == 13'h1FFF) o = 1'b1;
				{h, l[4:0]} = {h, l[4:0]} + 13'h0001;
				l[7:5] = 3'h0;
			end else if (m == 2'b01) begin
				if ({h, l} == 16'hFFFF) o = 1'b1;
				{h, l} = {h, l} + 16'h0001;
			end else if (l == 8'hFF) begin
				o = 1'b1;
				l = h;
			end else l = l + 8'h01;
		end
		return {o, h, l};
	endfunction : model

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_b = 1'b0;
		{cyc, stb, we, adr, wdat} = '0;
		sel = 4'h0;
		lanes = 4'hF;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 8'h88; i <= 8'h91; i++) rd("reset", 8'(i), 8'h00);
		wr(8'h8E, 8'h5A);
		rd("unmapped", 8'h8E, 8'h00);
		for (int i = 8'h8A; i <= 8'h8D; i++) begin
			a = 8'($random(seed));
			wr(8'(i), a);
			rd("count byte", 8'(i), a);
		end
		wr(8'h91, 8'h03);
		// Modes 00..10 on both timers, gated so the count is exact
		for (int t = 0; t < 2; t++) for (int m = 0; m < 3; m++) for (int r = 0; r < 2; r++) begin
			wr(8'h88, 8'h00);
			wr(8'h89, 8'(8 + m) << (4 * t));
			lo = 8'($random(seed));
			hi = 8'($random(seed));
			n = 1 + {$random(seed)} % 6;
			if (r == 1) begin
				lo = lo | 8'hFC;
				hi = 8'hFF;
				n = 6;
			end
			wr(8'(8'h8A + t), lo);
			wr(8'(8'h8C + t), hi);
			wr(8'h88, 8'(8'h10 << (2 * t)));
			u_pins.gate(t, n);
			repeat (6) @(posedge clk);
			e = model(2'(m), lo, hi, n);
			rd("low", 8'(8'h8A + t), e[7:0]);
			rd("high", 8'(8'h8C + t), e[15:8]);
			`CHK("irq", e[16], irq)
			rd("ctrl", 8'h88, 8'(8'h10 << (2 * t)) | (e[16] ? 8'(8'h20 << (2 * t)) : 8'h00));
			rd("stat", 8'h90, 8'({7'h00, e[16]} << t));
			`CHK("irq clear", 1'b0, irq)
			if (e[16]) begin
				wr(8'h92, 8'(1 << t));
				rd("serviced", 8'h88, 8'(8'h10 << (2 * t)));
			end
		end
		// Pin-driven counting, then pin edges while stopped
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h55);
		wr(8'h8A, 8'h00);
		wr(8'h8B, 8'h00);
		wr(8'h88, 8'h50);
		k0 = 1 + {$random(seed)} % 5;
		k1 = 1 + {$random(seed)} % 5;
		u_pins.edges(0, k0);
		u_pins.edges(1, k1);
		rd("pin count 0", 8'h8A, 8'(k0));
		rd("pin count 1", 8'h8B, 8'(k1));
		wr(8'h88, 8'h00);
		u_pins.edges(0, 3);
		rd("stopped", 8'h8A, 8'(k0));
		// Split mode: timer 0 halves apart, timer 1 halted
		wr(8'h89, 8'h3B);
		a = 8'($random(seed));
		wr(8'h8A, a);
		wr(8'h8B, a);
		wr(8'h8D, ~a);
		wr(8'h8C, 8'h00);
		wr(8'h88, 8'h50);
		u_pins.gate(0, 5);
		repeat (6) @(posedge clk);
		wr(8'h88, 8'h00);
		rd("split low", 8'h8A, a + 8'h05);
		// A write with byte lane 0 off must leave the count alone
		lanes = 4'hE;
		wr(8'h8A, ~a);
		lanes = 4'hF;
		rd("lane refused", 8'h8A, a + 8'h05);
		rd("halted low", 8'h8B, a);
		rd("halted high", 8'h8D, ~a);
		bus(1'b0, 8'h8C, 8'h00, q);
		`CHK("split high", 1'b1, q > 8'h0A)
		results();
	end
endmodule : dual_timer_counter_modes_test
